// [rtl/i2cfw_top.sv]
// Summary of operation
// - Start-fail and bus-busy flags (bits 7, 6) are read-only; writes ignored.
// - Reset clears the flag register and second control register to zero.
// - Start-fail sets on failed start with reservation disabled; clears on request/disable.
// - Busy sets on start or enabling with initial-start 0; clears on stop/disable.
// - Initial-start 0 waits for a stop before allowing start; 1 allows immediately.
// - Initial-start set only by write; cleared by write 0, start detection while enabled, reset.
// - Reservation-disable: 0 enables reservation, 1 disables; software only.
// - Wakeup bit 0 disables, 1 enables address-match wakeup in stop state.
// - Match and extension interrupts keep their timing with wakeup enabled.
// - Wakeup bit 1 suppresses the stop-condition interrupt regardless of its enable.
// - While enabled, monitor bits show sampled clock and data levels; disable clears.
// - Speed bit picks standard or fast; filter acts only in fast mode.
`timescale 1ns/1ps
module i2cfw_top (
  // System clock, reset, enable
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  // Link sampling clock
  input wire logic LINK_CLK,
  // CPU register access
  input wire logic [15:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  // From the first control register and the engine
  input wire logic OPERATION_ENABLE,
  input wire logic STOP_INTERRUPT_ENABLE,
  input wire logic START_REQUEST_SET,
  input wire logic START_GEN_FAIL,
  // Events from the engine on the link clock
  input wire logic ADDRESS_MATCH_EV,
  input wire logic EXTENSION_CODE_EV,
  // Bus lines as seen at the pins
  input wire logic BUS_CLOCK_PIN,
  input wire logic BUS_DATA_PIN,
  // Status and mode towards the engine
  output logic START_ALLOWED,
  output logic BUS_BUSY,
  output i2cfw_pkg::i2cfw_mode_t MODE,
  // Interrupt pulses
  output logic STOP_IRQ,
  output logic ADDRESS_MATCH_IRQ,
  output logic EXTENSION_CODE_IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: line sampling and condition detection

  i2cfw_pkg::i2cfw_pins_t link_pins;
  i2cfw_pkg::i2cfw_pins_t link_prev_q;
  i2cfw_pkg::i2cfw_evt_t link_tgl_q;
  logic link_start;
  logic link_stop;

  i2cfw_sync #(
    .W(2),
    .INIT(i2cfw_pkg::PINS_IDLE)
  ) u_link_pins (
    .clk(LINK_CLK),
    .nrst(NRST),
    .ce(1'b1),
    .d({BUS_CLOCK_PIN, BUS_DATA_PIN}),
    .q(link_pins)
  );

  always_ff @(posedge LINK_CLK or negedge NRST) begin
    if (!NRST) begin
      link_prev_q <= i2cfw_pkg::PINS_IDLE;
    end else begin
      link_prev_q <= link_pins;
    end
  end

  // Data falling while clock high is a start, rising is a stop
  assign link_start = link_pins.clock_line && link_prev_q.clock_line &&
                      link_prev_q.data_line && !link_pins.data_line;
  assign link_stop = link_pins.clock_line && link_prev_q.clock_line &&
                     !link_prev_q.data_line && link_pins.data_line;

  // Toggles carry each event into the system domain
  always_ff @(posedge LINK_CLK or negedge NRST) begin
    if (!NRST) begin
      link_tgl_q <= '0;
    end else begin
      link_tgl_q.start <= link_tgl_q.start ^ link_start;
      link_tgl_q.stop <= link_tgl_q.stop ^ link_stop;
      link_tgl_q.match <= link_tgl_q.match ^ ADDRESS_MATCH_EV;
      link_tgl_q.ext <= link_tgl_q.ext ^ EXTENSION_CODE_EV;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossings into the system domain

  i2cfw_pkg::i2cfw_evt_t sys_tgl;
  i2cfw_pkg::i2cfw_evt_t sys_tgl_prev_q;
  i2cfw_pkg::i2cfw_evt_t det;
  i2cfw_pkg::i2cfw_pins_t sys_pins;

  i2cfw_sync #(
    .W(4),
    .INIT(4'h0)
  ) u_evt_sync (
    .clk(CLK),
    .nrst(NRST),
    .ce(CE),
    .d(link_tgl_q),
    .q(sys_tgl)
  );

  i2cfw_sync #(
    .W(2),
    .INIT(i2cfw_pkg::PINS_IDLE)
  ) u_sys_pins (
    .clk(CLK),
    .nrst(NRST),
    .ce(CE),
    .d({BUS_CLOCK_PIN, BUS_DATA_PIN}),
    .q(sys_pins)
  );

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sys_tgl_prev_q <= '0;
    end else if (CE) begin
      sys_tgl_prev_q <= sys_tgl;
    end
  end

  // One-cycle event pulses, gated so a frozen clock enable cannot lose them
  assign det = (sys_tgl ^ sys_tgl_prev_q) & {4{CE}};

  ////////////////////////////////////////////////////////////////////////////
  // Register access decode

  logic wr_flags;
  logic wr_mode;
  logic op_prev_q;
  logic op_rise;

  assign wr_flags = CE && WR_EN && (ADDR == i2cfw_pkg::ADDR_BUS_FLAGS);
  assign wr_mode = CE && WR_EN && (ADDR == i2cfw_pkg::ADDR_MODE_MON);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      op_prev_q <= 1'b0;
    end else if (CE) begin
      op_prev_q <= OPERATION_ENABLE;
    end
  end

  assign op_rise = OPERATION_ENABLE && !op_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus flag register

  logic start_fail_flag_q;
  logic bus_busy_flag_q;
  logic initial_start_enable_q;
  logic reservation_disable_q;

  // Failure only latches when reservation is off; set beats the clearing request
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      start_fail_flag_q <= 1'b0;
    end else if (CE) begin
      if (!OPERATION_ENABLE) begin
        start_fail_flag_q <= 1'b0;
      end else if (START_GEN_FAIL && reservation_disable_q) begin
        start_fail_flag_q <= 1'b1;
      end else if (START_REQUEST_SET) begin
        start_fail_flag_q <= 1'b0;
      end
    end
  end

  // Busy tracks the bus; only hardware sets or clears it
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      bus_busy_flag_q <= 1'b0;
    end else if (CE) begin
      if (!OPERATION_ENABLE) begin
        bus_busy_flag_q <= 1'b0;
      end else if (det.start || (op_rise && !initial_start_enable_q)) begin
        bus_busy_flag_q <= 1'b1;
      end else if (det.stop) begin
        bus_busy_flag_q <= 1'b0;
      end
    end
  end

  // Write wins over start-detect clear; starts seen while stopped must not undo setup
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      initial_start_enable_q <= 1'b0;
    end else if (CE) begin
      if (wr_flags) begin
        initial_start_enable_q <= WDATA[i2cfw_pkg::BIT_INIT_START];
      end else if (det.start && OPERATION_ENABLE) begin
        initial_start_enable_q <= 1'b0;
      end
    end
  end

  // Written regardless of operation state; software keeps the ordering
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      reservation_disable_q <= 1'b0;
    end else if (CE && wr_flags) begin
      reservation_disable_q <= WDATA[i2cfw_pkg::BIT_RSV_DISABLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start permission

  // Without the initial-start option, a stop must be seen first
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      START_ALLOWED <= 1'b0;
    end else if (CE) begin
      if (!OPERATION_ENABLE) begin
        START_ALLOWED <= 1'b0;
      end else if (op_rise) begin
        START_ALLOWED <= initial_start_enable_q;
      end else if (det.stop) begin
        START_ALLOWED <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and pin monitor register

  logic match_wakeup_control_q;
  logic speed_mode_select_q;
  logic noise_filter_enable_q;
  logic clock_line_level_q;
  logic data_line_level_q;

  // Wakeup may change while running; the rest is expected only while disabled
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      match_wakeup_control_q <= 1'b0;
    end else if (CE && wr_mode) begin
      match_wakeup_control_q <= WDATA[i2cfw_pkg::BIT_WAKEUP];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      speed_mode_select_q <= 1'b0;
      noise_filter_enable_q <= 1'b0;
    end else if (CE && wr_mode) begin
      speed_mode_select_q <= WDATA[i2cfw_pkg::BIT_SPEED];
      noise_filter_enable_q <= WDATA[i2cfw_pkg::BIT_FILTER];
    end
  end

  // Monitors are not writable; they follow the lines only while enabled
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      clock_line_level_q <= 1'b0;
      data_line_level_q <= 1'b0;
    end else if (CE) begin
      clock_line_level_q <= OPERATION_ENABLE && sys_pins.clock_line;
      data_line_level_q <= OPERATION_ENABLE && sys_pins.data_line;
    end
  end

  // Filter is meaningless in standard mode, so it is masked there
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      MODE <= '0;
    end else if (CE) begin
      MODE.wakeup <= match_wakeup_control_q;
      MODE.speed_fast <= speed_mode_select_q;
      MODE.filter_active <= speed_mode_select_q && noise_filter_enable_q;
      MODE.rsv_disable <= reservation_disable_q;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      BUS_BUSY <= 1'b0;
    end else if (CE) begin
      BUS_BUSY <= bus_busy_flag_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pulses

  // Match and extension are gated only by operation enable; only sampling delay added
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ADDRESS_MATCH_IRQ <= 1'b0;
      EXTENSION_CODE_IRQ <= 1'b0;
    end else if (CE) begin
      ADDRESS_MATCH_IRQ <= det.match && OPERATION_ENABLE;
      EXTENSION_CODE_IRQ <= det.ext && OPERATION_ENABLE;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      STOP_IRQ <= 1'b0;
    end else if (CE) begin
      STOP_IRQ <= det.stop && OPERATION_ENABLE && STOP_INTERRUPT_ENABLE &&
                  !match_wakeup_control_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [7:0] flags_view;
  logic [7:0] mode_view;
  logic [7:0] rdata_d;

  // Unused positions are constant zero
  always_comb begin
    flags_view = 8'h00;
    flags_view[i2cfw_pkg::BIT_START_FAIL] = start_fail_flag_q;
    flags_view[i2cfw_pkg::BIT_BUS_BUSY] = bus_busy_flag_q;
    flags_view[i2cfw_pkg::BIT_INIT_START] = initial_start_enable_q;
    flags_view[i2cfw_pkg::BIT_RSV_DISABLE] = reservation_disable_q;
  end

  always_comb begin
    mode_view = 8'h00;
    mode_view[i2cfw_pkg::BIT_WAKEUP] = match_wakeup_control_q;
    mode_view[i2cfw_pkg::BIT_CLOCK_LEVEL] = clock_line_level_q;
    mode_view[i2cfw_pkg::BIT_DATA_LEVEL] = data_line_level_q;
    mode_view[i2cfw_pkg::BIT_SPEED] = speed_mode_select_q;
    mode_view[i2cfw_pkg::BIT_FILTER] = noise_filter_enable_q;
  end

  always_comb begin
    rdata_d = i2cfw_pkg::RDATA_IDLE;
    case (ADDR)
      i2cfw_pkg::ADDR_BUS_FLAGS: begin
        rdata_d = flags_view;
      end
      i2cfw_pkg::ADDR_MODE_MON: begin
        rdata_d = mode_view;
      end
      default: begin
        rdata_d = i2cfw_pkg::RDATA_IDLE;
      end
    endcase
  end

  // Read data holds until the next read
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= i2cfw_pkg::RDATA_IDLE;
    end else if (CE && RD_EN) begin
      RDATA <= rdata_d;
    end
  end

endmodule

// [rtl/i2cfw_pkg.sv]
package i2cfw_pkg;

  // Register addresses on the CPU data space
  localparam logic [15:0] ADDR_MODE_MON = 16'hFFA8;
  localparam logic [15:0] ADDR_BUS_FLAGS = 16'hFFA9;

  // Values after reset
  localparam logic [7:0] RST_MODE_MON = 8'h00;
  localparam logic [7:0] RST_BUS_FLAGS = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  // Bus flag register fields
  localparam int BIT_START_FAIL = 7;
  localparam int BIT_BUS_BUSY = 6;
  localparam int BIT_INIT_START = 1;
  localparam int BIT_RSV_DISABLE = 0;

  // Mode and pin monitor register fields
  localparam int BIT_WAKEUP = 7;
  localparam int BIT_CLOCK_LEVEL = 5;
  localparam int BIT_DATA_LEVEL = 4;
  localparam int BIT_SPEED = 3;
  localparam int BIT_FILTER = 2;

  // Synchroniser depth for pins and toggles
  localparam int SYNC_STAGES = 3;

  // Levels that the two bus lines rest at
  localparam logic [1:0] PINS_IDLE = 2'h3;

  // Events raised at the link
  typedef struct packed {
    logic start;
    logic stop;
    logic match;
    logic ext;
  } i2cfw_evt_t;

  // Sampled bus lines
  typedef struct packed {
    logic clock_line;
    logic data_line;
  } i2cfw_pins_t;

  // Mode outputs towards the protocol engine
  typedef struct packed {
    logic wakeup;
    logic speed_fast;
    logic filter_active;
    logic rsv_disable;
  } i2cfw_mode_t;

endpackage

// [rtl/i2cfw_sync.sv]
`timescale 1ns/1ps
module i2cfw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else if (ce) begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit changes only once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= INIT;
    end else if (ce) begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

// [tb/i2cfw_top_props.sv]
`timescale 1ns/1ps
module i2cfw_top_props (
  // Clocks and reset
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  // Register access
  input wire logic [15:0] ADDR,
  input wire logic RD_EN,
  input wire logic [7:0] RDATA,
  // Control
  input wire logic OPERATION_ENABLE,
  input wire logic STOP_INTERRUPT_ENABLE,
  // Status and interrupts
  input wire logic START_ALLOWED,
  input wire logic BUS_BUSY,
  input wire i2cfw_pkg::i2cfw_mode_t MODE,
  input wire logic STOP_IRQ,
  input wire logic ADDRESS_MATCH_IRQ,
  input wire logic EXTENSION_CODE_IRQ
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  wire rd_f = RD_EN && CE && ADDR == i2cfw_pkg::ADDR_BUS_FLAGS;
  wire rd_m = RD_EN && CE && ADDR == i2cfw_pkg::ADDR_MODE_MON;
  wire rd_x = RD_EN && CE && !rd_f && !rd_m;
  wire any_ev = ADDRESS_MATCH_IRQ || EXTENSION_CODE_IRQ;
  ////////////////////////////////////////////////////////////////////////////////
  AST_RD_UNMAPPED: assert property (rd_x |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  AST_FLAGS_SPARE: assert property (rd_f |=> RDATA[5:2] == 4'h0)
    else $error("flag register spare bits set");
  AST_MODE_SPARE: assert property (rd_m |=> RDATA[6] == 1'b0 && RDATA[1:0] == 2'h0)
    else $error("mode register spare bits set");
  AST_MON_OFF: assert property (rd_m && !OPERATION_ENABLE && !$past(OPERATION_ENABLE)
    |=> RDATA[5:4] == 2'h0) else $error("monitor bits set while disabled");
  AST_FLAGS_OFF: assert property (rd_f && !OPERATION_ENABLE && !$past(OPERATION_ENABLE)
    |=> RDATA[7:6] == 2'h0) else $error("status flags set while disabled");
  AST_STOP_GATE: assert property (STOP_IRQ
    |-> !MODE.wakeup && $past(STOP_INTERRUPT_ENABLE))
    else $error("stop interrupt not suppressed");
  AST_STOP_FREE: assert property (STOP_IRQ |-> START_ALLOWED ##1 !BUS_BUSY)
    else $error("stop did not free the bus");
  AST_ALLOW_OFF: assert property (!OPERATION_ENABLE && !$past(OPERATION_ENABLE)
    |-> !START_ALLOWED) else $error("start allowed while disabled");
  AST_BUSY_OFF: assert property ((!OPERATION_ENABLE)[*3] |-> !BUS_BUSY)
    else $error("busy while disabled");
  AST_IRQ_ONE: assert property (any_ev |=> !ADDRESS_MATCH_IRQ && !EXTENSION_CODE_IRQ)
    else $error("event interrupt longer than one cycle");
  AST_FILTER: assert property (MODE.filter_active |-> MODE.speed_fast)
    else $error("filter active outside fast mode");
  AST_CE_HOLD: assert property (!CE |=> $stable(RDATA) && $stable(MODE) &&
    $stable(START_ALLOWED) && $stable(BUS_BUSY) && $stable(STOP_IRQ))
    else $error("outputs moved with clock enable low");
  cover property (STOP_IRQ);
  cover property (ADDRESS_MATCH_IRQ);
  cover property (EXTENSION_CODE_IRQ);
endmodule
bind i2cfw_top i2cfw_top_props props_i (.CLK(CLK), .NRST(NRST), .CE(CE), .ADDR(ADDR),
  .RD_EN(RD_EN), .RDATA(RDATA), .OPERATION_ENABLE(OPERATION_ENABLE),
  .STOP_INTERRUPT_ENABLE(STOP_INTERRUPT_ENABLE), .START_ALLOWED(START_ALLOWED),
  .BUS_BUSY(BUS_BUSY), .MODE(MODE), .STOP_IRQ(STOP_IRQ),
  .ADDRESS_MATCH_IRQ(ADDRESS_MATCH_IRQ), .EXTENSION_CODE_IRQ(EXTENSION_CODE_IRQ));

// [tb/i2cfw_bus_peer.sv]
`timescale 1ns/1ps
module i2cfw_bus_peer (
  // Link clock
  input wire logic link_clk,
  // Lines, pulled up when released
  output logic scl,
  output logic sda,
  // Engine event pulses
  output logic match_ev,
  output logic ext_ev
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    match_ev = 1'b0;
    ext_ev = 1'b0;
  end
  // Five link cycles per level so the synchronisers agree
  task automatic step(input logic c, input logic dl);
    @(posedge link_clk);
    #1;
    scl = c;
    sda = dl;
    repeat (4) @(posedge link_clk);
  endtask
  task automatic start_cond();
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  // Data moves with clock low until the final rise, so no false start on the way
  task automatic stop_cond();
    step(1'b0, 1'b1);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  // Gap of two link cycles keeps events apart
  task automatic pulse(input logic ext);
    @(posedge link_clk);
    #1;
    match_ev = !ext;
    ext_ev = ext;
    @(posedge link_clk);
    #1;
    match_ev = 1'b0;
    ext_ev = 1'b0;
    repeat (2) @(posedge link_clk);
  endtask
endmodule

// [tb/tb_i2c_flag_and_wakeup_control.sv]
`timescale 1ns/1ps
module tb_i2c_flag_and_wakeup_control;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic op_en = 1'b0;
  logic sie = 1'b1;
  logic req = 1'b0;
  logic fail = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic rsv = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] a;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, d;
  logic scl, sda, m_ev, x_ev, allowed, busy, s_irq, m_irq, x_irq;
  i2cfw_pkg::i2cfw_mode_t mode;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  int stop_n = 0;
  int match_n = 0;
  int ext_n = 0;
  i2cfw_bus_peer peer (.link_clk(lclk), .scl(scl), .sda(sda), .match_ev(m_ev), .ext_ev(x_ev));
  i2cfw_top uut (.CLK(clk), .NRST(nrst), .CE(ce), .LINK_CLK(lclk), .ADDR(addr),
    .WR_EN(wr_en), .RD_EN(rd_en), .WDATA(wdata), .RDATA(rdata), .OPERATION_ENABLE(op_en),
    .STOP_INTERRUPT_ENABLE(sie), .START_REQUEST_SET(req), .START_GEN_FAIL(fail),
    .ADDRESS_MATCH_EV(m_ev), .EXTENSION_CODE_EV(x_ev), .BUS_CLOCK_PIN(scl),
    .BUS_DATA_PIN(sda), .START_ALLOWED(allowed), .BUS_BUSY(busy), .MODE(mode),
    .STOP_IRQ(s_irq), .ADDRESS_MATCH_IRQ(m_irq), .EXTENSION_CODE_IRQ(x_irq));
  always #5 clk = ~clk;
  initial begin
    #3;
    forever #80 lclk = ~lclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Ceiling well above the expected run of about 4000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (s_irq === 1'b1) stop_n <= stop_n + 1;
    if (m_irq === 1'b1) match_n <= match_n + 1;
    if (x_irq === 1'b1) ext_n <= ext_n + 1;
    if (cycles == 40000) begin
      failures = failures + 1;
      close_out();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] exp_rd(input logic [15:0] ad, input logic [7:0] dv);
    if (ad == i2cfw_pkg::ADDR_BUS_FLAGS) return dv & 8'h03;
    if (ad == i2cfw_pkg::ADDR_MODE_MON) return dv & 8'h8C;
    return 8'h00;
  endfunction
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] ad, input logic [7:0] dv);
    @(posedge clk);
    #1;
    addr = ad;
    wdata = dv;
    wr_en = 1'b1;
    @(posedge clk);
    #1;
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [15:0] ad, input logic [7:0] e);
    @(posedge clk);
    #1;
    addr = ad;
    rd_en = 1'b1;
    @(posedge clk);
    #1;
    rd_en = 1'b0;
    chk(rdata, e);
  endtask
  task automatic pulse(input logic k);
    @(posedge clk);
    #1;
    fail = !k;
    req = k;
    @(posedge clk);
    #1;
    fail = 1'b0;
    req = 1'b0;
  endtask
  task automatic en(input logic v);
    @(posedge clk);
    #1;
    op_en = v;
    settle(8);
  endtask
  // Link detection takes tens of cycles, so wait generously
  task automatic irqs(input int es, input int em, input int ee);
    settle(100);
    chk(8'(stop_n), 8'(es));
    chk(8'(match_n), 8'(em));
    chk(8'(ext_n), 8'(ee));
    stop_n = 0;
    match_n = 0;
    ext_n = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h5D0D));
    repeat (12) @(posedge clk);
    #1;
    nrst = 1'b1;
    rd(16'hFFA9, 8'h00);
    rd(16'hFFA8, 8'h00);
    for (int i = 0; i < 20; i++) begin
      a = 16'hFFA8 + 16'($urandom % 3);
      d = (i < 2) ? {8{i[0]}} : 8'($urandom);
      wr(a, d);
      rd(a, exp_rd(a, d));
      if (a == 16'hFFA9) rsv = d[0];
      if (a == 16'hFFA8) chk({4'h0, mode}, {4'h0, d[7], d[3], d[3] & d[2], rsv});
    end
    wr(16'hFFA8, 8'h00);
    wr(16'hFFA9, 8'h00);
    // Writes under a frozen clock enable must be lost
    ce = 1'b0;
    wr(16'hFFA8, 8'h8C);
    wr(16'hFFA9, 8'h03);
    ce = 1'b1;
    rd(16'hFFA8, 8'h00);
    rd(16'hFFA9, 8'h00);
    en(1'b1);
    chk({7'h0, busy}, 8'h01);
    chk({7'h0, allowed}, 8'h00);
    rd(16'hFFA8, 8'h30);
    peer.stop_cond();
    irqs(1, 0, 0);
    chk({7'h0, busy}, 8'h00);
    chk({7'h0, allowed}, 8'h01);
    peer.start_cond();
    irqs(0, 0, 0);
    rd(16'hFFA9, 8'h40);
    rd(16'hFFA8, 8'h00);
    peer.stop_cond();
    irqs(1, 0, 0);
    en(1'b0);
    wr(16'hFFA9, 8'h02);
    en(1'b1);
    rd(16'hFFA9, 8'h02);
    chk({7'h0, allowed}, 8'h01);
    peer.start_cond();
    irqs(0, 0, 0);
    rd(16'hFFA9, 8'h40);
    peer.stop_cond();
    irqs(1, 0, 0);
    pulse(1'b0);
    rd(16'hFFA9, 8'h00);
    en(1'b0);
    wr(16'hFFA9, 8'h01);
    en(1'b1);
    pulse(1'b0);
    rd(16'hFFA9, 8'hC1);
    pulse(1'b1);
    rd(16'hFFA9, 8'h41);
    pulse(1'b0);
    en(1'b0);
    rd(16'hFFA9, 8'h01);
    wr(16'hFFA9, 8'h00);
    en(1'b1);
    peer.stop_cond();
    irqs(1, 0, 0);
    wr(16'hFFA8, 8'h80);
    settle(3);
    chk({4'h0, mode}, 8'h08);
    peer.start_cond();
    peer.stop_cond();
    peer.pulse(1'b0);
    peer.pulse(1'b1);
    irqs(0, 1, 1);
    wr(16'hFFA8, 8'h00);
    sie = 1'b0;
    peer.start_cond();
    peer.stop_cond();
    irqs(0, 0, 0);
    close_out();
  end
endmodule
